// ### rtl/mci_pkg.sv
// Constants, types and encodings for the mailbox command interpreter.
// Assumes one device clock for the interpreter and a separate link clock for the host port.
// Functional notes
// RULE1: Host sends a request packet; device answers with response packet, status-only answers optional.
// RULE2: Code 0x01 memory access is refused with security violation while secured.
// RULE3: Code 0x02 flash erase; while secured only the mass-erase form runs.
// RULE4: Code 0x04 checksum over a range is refused with security violation while secured.
// RULE5: Code 0x05 resets the device, allowed when secured, with no response packet.
// RULE6: Code 0x00 device information stays executable while secured.
// RULE7: Codes 0x07/0x08 set and clear write lock; never touch the secured state.
// RULE8: Host must unlock writes before mass-erasing a secured device.
// RULE9: Any undefined command code completes with the unknown-request error.
// RULE10: Mailbox 1 bit 7 is the completion flag, bits 6-4 the error code.
// RULE11: Flag cleared when a command is taken, set when processing ends.
// RULE12: Host treats upper nibble 0x0-0x7 of mailbox 1 as still executing.
// RULE13: Success is error code 000, upper nibble 0x8.
// RULE14: Bad input parameter is error code 001, upper nibble 0x9.
// RULE15: Program or erase while write lock low bit is 0 gives code 010.
// RULE16: Prohibited function while security state is 10 gives code 011.
// RULE17: Verify only with verify bit; mismatch gives 100 and offset in mailboxes 2-3.
// RULE18: Missing access rights, such as writing read-only memory, give code 101.
// RULE19: Out-of-range parameter, such as crossing a flash row, gives code 110.
// RULE20: Unknown code or incomplete request packet gives code 111.
// RULE21: Device information returns 32-bit identifier, versions, and secured state in error field.
// RULE22: Security state code 10 means secured; 00, 01 and 11 mean unsecured.
// RULE23: Mailbox 0 of every response echoes the request command byte.
// RULE24: One command at a time; host waits for flag 1 before reading or writing.
// RULE25: Decode only after whole request written; mailboxes unchanged until flag set.
package mci_pkg;

    localparam int          MBX_N      = 32;
    localparam int          MBX_AW     = 5;
    // Command codes in bits 7:3 of the command byte
    localparam logic [4:0]  CMD_INFO   = 5'h00;
    localparam logic [4:0]  CMD_MEM    = 5'h01;
    localparam logic [4:0]  CMD_ERASE  = 5'h02;
    localparam logic [4:0]  CMD_CSUM   = 5'h04;
    localparam logic [4:0]  CMD_RESET  = 5'h05;
    localparam logic [4:0]  CMD_LOCK   = 5'h07;
    localparam logic [4:0]  CMD_UNLOCK = 5'h08;
    // Command byte and mailbox 1 fields
    localparam int          CODE_LSB   = 3;
    localparam int          VERIFY_BIT = 1;
    localparam int          WRITE_BIT  = 0;
    localparam int          MASS_BIT   = 0;
    localparam int          FLAG_BIT   = 7;
    localparam int          ERR_LSB    = 4;
    // Error codes
    localparam logic [2:0]  ST_OK      = 3'h0;
    localparam logic [2:0]  ST_PARAM   = 3'h1;
    localparam logic [2:0]  ST_LOCKED  = 3'h2;
    localparam logic [2:0]  ST_SECURED = 3'h3;
    localparam logic [2:0]  ST_VERIFY  = 3'h4;
    localparam logic [2:0]  ST_RIGHTS  = 3'h5;
    localparam logic [2:0]  ST_RANGE   = 3'h6;
    localparam logic [2:0]  ST_UNKNOWN = 3'h7;
    localparam logic [1:0]  SSC_SECURE = 2'h2;
    // Mailbox indices
    localparam logic [4:0]  MB_CMD     = 5'h00;
    localparam logic [4:0]  MB_STAT    = 5'h01;
    localparam logic [4:0]  MB_ID      = 5'h02;
    localparam logic [4:0]  MB_VER     = 5'h06;
    localparam logic [4:0]  MB_ADDR_HI = 5'h06;
    localparam logic [4:0]  MB_ADDR_LO = 5'h07;
    localparam logic [4:0]  MB_SSC     = 5'h11;
    // Request packet lengths in mailboxes
    localparam logic [5:0]  LEN_SHORT  = 6'h02;
    localparam logic [5:0]  LEN_FULL   = 6'h08;
    localparam logic [5:0]  LEN_RESET  = 6'h01;

    typedef enum logic [3:0] {
        MCI_IDLE   = 4'h1,
        MCI_DECODE = 4'h2,
        MCI_WAIT   = 4'h4
    } mci_state_t;

    typedef enum logic [1:0] {
        MCI_OP_MEM   = 2'h0,
        MCI_OP_ERASE = 2'h1,
        MCI_OP_CSUM  = 2'h2
    } mci_op_kind_t;

    // Request handed to the memory engine
    typedef struct packed {
        mci_op_kind_t kind;
        logic         write;
        logic         verify;
        logic         mass;
        logic [7:0]   param;
        logic [15:0]  addr;
    } mci_op_t;

    // Answer from the memory engine
    typedef struct packed {
        logic [2:0]   status;
        logic [15:0]  offset;
    } mci_res_t;

endpackage : mci_pkg

// ### rtl/mci_core.sv
// Mailbox command interpreter: host mailbox port on the link clock, interpreter on clk_i.
// Assumes a memory engine on clk_i that answers op_req_o with one op_done_i pulse.
`timescale 1ns/1ns
module mci_core #(
    parameter logic [31:0] DEV_ID  = 32'h0000_0a5c, // Arbitrary identifier value
    parameter logic [47:0] VERSION = 48'h0001_0001_0001
) (
    // Device clock and reset
    input  wire logic               clk_i,
    input  wire logic               sys_rst_i,
    // Host mailbox port, link clock
    input  wire logic               lk_clk_i,
    input  wire logic               lk_wr_i,
    input  wire logic               lk_rd_i,
    input  wire logic [4:0]         lk_addr_i,
    input  wire logic [7:0]         lk_wdata_i,
    output logic                    lk_ready_o,
    output logic                    lk_rvalid_o,
    output logic [7:0]              lk_rdata_o,
    // Option bits
    input  wire logic [1:0]         security_state_code_i,
    input  wire logic               flash_write_lock_low_i,
    // Memory engine
    output logic                    op_req_o,
    output mci_pkg::mci_op_t        op_o,
    input  wire logic               op_done_i,
    input  wire mci_pkg::mci_res_t  op_res_i,
    // Side effects
    output logic                    reset_req_o,
    output logic                    lock_set_o,
    output logic                    lock_clr_o,
    output logic                    busy_o
);

    // Only the value 10 means secured
    function automatic logic is_secured(input logic [1:0] ssc);
        return ssc == mci_pkg::SSC_SECURE; // RULE22
    endfunction : is_secured

    // Status byte: flag, error code, untouched low nibble
    function automatic logic [7:0] stat_byte(input logic done, input logic [2:0] err, input logic [3:0] low);
        return {done, err, low}; // RULE10
    endfunction : stat_byte

    // ---------------- Link domain ----------------
    logic                      lk_tgl_q;
    logic                      lk_is_rd_q;
    logic [4:0]                lk_addr_q;
    logic [7:0]                lk_wdata_q;
    logic [2:0]                lk_ack_s_q;
    logic                      lk_ack_seen_q;
    logic                      ack_tgl_q;
    logic [7:0]                rd_hold_q;

    // One access in flight; a new one is taken only once the last was acknowledged
    always_ff @(posedge lk_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lk_tgl_q   <= 1'b0;
            lk_is_rd_q <= 1'b0;
            lk_addr_q  <= 5'h00;
            lk_wdata_q <= 8'h00;
            lk_ready_o <= 1'b0;
        end else if (lk_ready_o && (lk_wr_i || lk_rd_i)) begin
            lk_tgl_q   <= ~lk_tgl_q;
            lk_is_rd_q <= lk_rd_i;
            lk_addr_q  <= lk_addr_i;
            lk_wdata_q <= lk_wdata_i;
            lk_ready_o <= 1'b0;
        end else begin
            lk_ready_o <= lk_ack_s_q[2] == lk_ack_s_q[1] && lk_ack_s_q[2] == lk_tgl_q;
        end
    end

    // Acknowledge toggle back from the device clock; only stage 1 reads stage 0
    always_ff @(posedge lk_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lk_ack_s_q <= 3'h0;
        end else begin
            lk_ack_s_q <= {lk_ack_s_q[1:0], ack_tgl_q};
        end
    end

    // Read data is loaded into rd_hold_q on the same edge the acknowledge toggles, so it is stable before the link sees the toggle
    always_ff @(posedge lk_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lk_ack_seen_q <= 1'b0;
            lk_rvalid_o   <= 1'b0;
            lk_rdata_o    <= 8'h00;
        end else begin
            lk_rvalid_o <= 1'b0;
            if (lk_ack_s_q[2] == lk_ack_s_q[1] && lk_ack_s_q[2] != lk_ack_seen_q) begin
                lk_ack_seen_q <= lk_ack_s_q[2];
                lk_rvalid_o   <= lk_is_rd_q;
                if (lk_is_rd_q) begin
                    lk_rdata_o <= rd_hold_q;
                end
            end
        end
    end

    // ---------------- Device domain ----------------
    logic [2:0]                req_s_q;
    logic                      req_seen_q;
    logic                      acc_ev;
    logic [7:0]                mbx_q [mci_pkg::MBX_N];
    logic [mci_pkg::MBX_N-1:0] written_q;
    logic [7:0]                cmd_q;
    mci_pkg::mci_state_t       st_q;
    logic                      secured;
    logic [4:0]                code;
    logic [5:0]                need_len;
    logic                      complete;

    assign secured = is_secured(security_state_code_i);
    assign code    = cmd_q[7:mci_pkg::CODE_LSB];
    assign acc_ev  = req_s_q[2] == req_s_q[1] && req_s_q[2] != req_seen_q;

    // Mailboxes that each command needs before it may be decoded
    always_comb begin
        need_len = mci_pkg::LEN_FULL;
        unique case (code)
            mci_pkg::CMD_INFO, mci_pkg::CMD_LOCK,
            mci_pkg::CMD_UNLOCK: need_len = mci_pkg::LEN_SHORT;
            mci_pkg::CMD_RESET:  need_len = mci_pkg::LEN_RESET;
            default:             need_len = mci_pkg::LEN_FULL;
        endcase
        complete = 1'b1;
        for (int i = 0; i < int'(mci_pkg::LEN_FULL); i++) begin
            if (i < int'(need_len) && !written_q[i]) begin
                complete = 1'b0;
            end
        end
    end

    // Request toggle from the link; filtered on stages 1 and 2
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_s_q    <= 3'h0;
            req_seen_q <= 1'b0;
            ack_tgl_q  <= 1'b0;
            rd_hold_q  <= 8'h00;
        end else begin
            req_s_q <= {req_s_q[1:0], lk_tgl_q};
            if (acc_ev) begin
                req_seen_q <= req_s_q[2];
                ack_tgl_q  <= ~ack_tgl_q;
                rd_hold_q  <= mbx_q[lk_addr_q];
            end
        end
    end

    // Command sequencer; a write to mailbox 0 closes the request packet
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= mci_pkg::MCI_IDLE;
        end else begin
            unique case (st_q)
                mci_pkg::MCI_IDLE: begin
                    if (acc_ev && !lk_is_rd_q && lk_addr_q == mci_pkg::MB_CMD) begin
                        st_q <= mci_pkg::MCI_DECODE; // RULE25
                    end
                end
                mci_pkg::MCI_DECODE: begin
                    // The engine request is only launched at this edge, so follow the decision itself
                    st_q <= dec_go ? mci_pkg::MCI_WAIT : mci_pkg::MCI_IDLE;
                end
                mci_pkg::MCI_WAIT: begin
                    if (op_done_i) begin
                        st_q <= mci_pkg::MCI_IDLE;
                    end
                end
                default: st_q <= mci_pkg::MCI_IDLE;
            endcase
        end
    end

    // Decision taken on the cycle the sequencer enters decode
    logic       dec_go;
    logic       dec_done;
    logic [2:0] dec_err;
    always_comb begin
        dec_go   = 1'b0;
        dec_done = 1'b1;
        dec_err  = mci_pkg::ST_OK;
        if (!complete) begin
            dec_err = mci_pkg::ST_UNKNOWN; // RULE20
        end else begin
            unique case (code)
                mci_pkg::CMD_INFO: begin
                    dec_err = secured ? mci_pkg::ST_SECURED : mci_pkg::ST_OK; // RULE6 RULE21
                end
                mci_pkg::CMD_MEM: begin
                    if (secured) begin
                        dec_err = mci_pkg::ST_SECURED; // RULE2 RULE16
                    end else if (cmd_q[mci_pkg::WRITE_BIT] && !flash_write_lock_low_i) begin
                        dec_err = mci_pkg::ST_LOCKED; // RULE15
                    end else begin
                        dec_go   = 1'b1;
                        dec_done = 1'b0;
                    end
                end
                mci_pkg::CMD_ERASE: begin
                    if (secured && !mbx_q[mci_pkg::MB_STAT][mci_pkg::MASS_BIT]) begin
                        dec_err = mci_pkg::ST_SECURED; // RULE3
                    end else if (!flash_write_lock_low_i) begin
                        dec_err = mci_pkg::ST_LOCKED; // RULE15 RULE8
                    end else begin
                        dec_go   = 1'b1;
                        dec_done = 1'b0;
                    end
                end
                mci_pkg::CMD_CSUM: begin
                    if (secured) begin
                        dec_err = mci_pkg::ST_SECURED; // RULE4
                    end else begin
                        dec_go   = 1'b1;
                        dec_done = 1'b0;
                    end
                end
                mci_pkg::CMD_RESET: begin
                    dec_done = 1'b0; // RULE5
                end
                mci_pkg::CMD_LOCK, mci_pkg::CMD_UNLOCK: begin
                    dec_err = mci_pkg::ST_OK; // RULE7
                end
                default: dec_err = mci_pkg::ST_UNKNOWN; // RULE9
            endcase
        end
    end

    // Engine status with verify results ignored unless the command asked for them
    logic [2:0] op_err;
    assign op_err = (op_res_i.status == mci_pkg::ST_VERIFY && !op_o.verify) ? mci_pkg::ST_OK : op_res_i.status;

    // Mailbox store; host writes are dropped while a command is in progress
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < mci_pkg::MBX_N; i++) begin
                mbx_q[i] <= 8'h00;
            end
            written_q <= '0;
            cmd_q     <= 8'h00;
        end else if (st_q == mci_pkg::MCI_IDLE) begin // RULE24
            if (acc_ev && !lk_is_rd_q) begin
                mbx_q[lk_addr_q]     <= lk_wdata_q;
                written_q[lk_addr_q] <= 1'b1;
                if (lk_addr_q == mci_pkg::MB_CMD) begin
                    cmd_q <= lk_wdata_q;
                    // Flag drops as soon as the command is taken
                    mbx_q[mci_pkg::MB_STAT] <= stat_byte(1'b0, mci_pkg::ST_OK,
                                                         mbx_q[mci_pkg::MB_STAT][3:0]); // RULE11
                end
            end
        end else if (st_q == mci_pkg::MCI_DECODE) begin
            written_q <= '0;
            if (dec_done) begin // RULE1
                mbx_q[mci_pkg::MB_CMD]  <= cmd_q; // RULE23
                mbx_q[mci_pkg::MB_STAT] <= stat_byte(1'b1, dec_err, mbx_q[mci_pkg::MB_STAT][3:0]); // RULE11 RULE13
                if (complete && code == mci_pkg::CMD_INFO) begin
                    for (int i = 0; i < 4; i++) begin
                        mbx_q[int'(mci_pkg::MB_ID) + i] <= DEV_ID[31-8*i -: 8]; // RULE21
                    end
                    for (int i = 0; i < 6; i++) begin
                        mbx_q[int'(mci_pkg::MB_VER) + i] <= VERSION[47-8*i -: 8];
                    end
                    mbx_q[mci_pkg::MB_SSC] <= {6'h00, security_state_code_i};
                end
            end
        end else if (op_done_i) begin
            mbx_q[mci_pkg::MB_CMD]  <= cmd_q; // RULE23
            // Engine reports parameter, rights, range and verify faults
            mbx_q[mci_pkg::MB_STAT] <= stat_byte(1'b1, op_err, mbx_q[mci_pkg::MB_STAT][3:0]); // RULE14 RULE18 RULE19
            if (op_err == mci_pkg::ST_VERIFY) begin
                mbx_q[mci_pkg::MB_ID]      <= op_res_i.offset[15:8]; // RULE17
                mbx_q[mci_pkg::MB_ID + 1]  <= op_res_i.offset[7:0];
            end
        end
    end

    // Engine request and side-effect pulses, one cycle each
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            op_req_o    <= 1'b0;
            op_o        <= '0;
            reset_req_o <= 1'b0;
            lock_set_o  <= 1'b0;
            lock_clr_o  <= 1'b0;
            busy_o      <= 1'b0;
        end else begin
            op_req_o    <= 1'b0;
            reset_req_o <= 1'b0;
            lock_set_o  <= 1'b0;
            lock_clr_o  <= 1'b0;
            busy_o      <= st_q != mci_pkg::MCI_IDLE || (acc_ev && !lk_is_rd_q && lk_addr_q == mci_pkg::MB_CMD);
            if (st_q == mci_pkg::MCI_IDLE && acc_ev && !lk_is_rd_q && lk_addr_q == mci_pkg::MB_CMD) begin
                // No engine request while a new command is only being taken
                op_req_o <= 1'b0;
            end
            if (st_q == mci_pkg::MCI_DECODE && complete) begin
                reset_req_o <= code == mci_pkg::CMD_RESET; // RULE5
                lock_set_o  <= code == mci_pkg::CMD_LOCK;  // RULE7
                lock_clr_o  <= code == mci_pkg::CMD_UNLOCK;
            end
            if (st_q == mci_pkg::MCI_DECODE && dec_go) begin
                op_req_o      <= 1'b1;
                op_o.kind     <= code == mci_pkg::CMD_MEM ? mci_pkg::MCI_OP_MEM :
                                 code == mci_pkg::CMD_ERASE ? mci_pkg::MCI_OP_ERASE : mci_pkg::MCI_OP_CSUM;
                op_o.write    <= cmd_q[mci_pkg::WRITE_BIT];
                op_o.verify   <= cmd_q[mci_pkg::VERIFY_BIT]; // RULE17
                op_o.mass     <= mbx_q[mci_pkg::MB_STAT][mci_pkg::MASS_BIT];
                op_o.param    <= mbx_q[mci_pkg::MB_STAT];
                op_o.addr     <= {mbx_q[mci_pkg::MB_ADDR_HI], mbx_q[mci_pkg::MB_ADDR_LO]};
            end
        end
    end

    // ---------------- Checks ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    logic dec;
    assign dec = st_q == mci_pkg::MCI_DECODE && complete;

    secured_mem_a: assert property (dec && code == mci_pkg::CMD_MEM && secured |=> // RULE2
        mbx_q[1][7:4] == 4'hb && !op_req_o) else $error("secured memory access not refused");
    page_erase_a: assert property (dec && code == mci_pkg::CMD_ERASE && secured && !mbx_q[1][0] |=> // RULE3
        mbx_q[1][7:4] == 4'hb) else $error("secured page erase not refused");
    secured_csum_a: assert property (dec && code == mci_pkg::CMD_CSUM && secured |=> // RULE4
        mbx_q[1][7:4] == 4'hb) else $error("secured checksum not refused");
    reset_quiet_a: assert property (dec && code == mci_pkg::CMD_RESET |=> // RULE5
        reset_req_o && $stable(mbx_q[1])) else $error("reset answered or not issued");
    info_reply_a: assert property (dec && code == mci_pkg::CMD_INFO |=> // RULE21
        mbx_q[2] == DEV_ID[31:24] && mbx_q[1][7:4] == ($past(secured) ? 4'hb : 4'h8))
        else $error("device info reply wrong");
    lock_pulse_a: assert property (dec && code == mci_pkg::CMD_UNLOCK |=> // RULE7
        lock_clr_o && !lock_set_o && mbx_q[1][7:4] == 4'h8) else $error("unlock not carried out");
    unknown_code_a: assert property (dec && !(code inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h07, 5'h08}) |=> // RULE9
        mbx_q[1][7:4] == 4'hf) else $error("unknown code not flagged");
    flag_clear_a: assert property ($rose(busy_o) |-> !mbx_q[1][7] && $past(st_q) == mci_pkg::MCI_IDLE) // RULE11
        else $error("flag not cleared on new command");
    echo_cmd_a: assert property ($rose(mbx_q[1][7]) |-> mbx_q[0] == cmd_q) // RULE23
        else $error("command byte not echoed");
    lock_stall_a: assert property (dec && code == mci_pkg::CMD_MEM && !secured && cmd_q[0] && !flash_write_lock_low_i // RULE15
        |=> mbx_q[1][7:4] == 4'ha ##1 st_q == mci_pkg::MCI_IDLE) else $error("locked write not refused");

    info_cov_c:   cover property (dec && code == mci_pkg::CMD_INFO);
    mem_op_c:     cover property (op_req_o ##[1:50] op_done_i);
    reset_cmd_c:  cover property (reset_req_o);
    unknown_c:    cover property (dec && code == 5'h1f);

endmodule : mci_core

// ### bench/mci_engine_model.sv
// Memory engine stand-in: answers each request after a fixed delay with a chosen status.
// Assumes one op_req_i pulse per request and no new request before the answer.
`timescale 1ns/1ns
module mci_engine_model #(
    parameter int DLY = 5
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    // Request and answer
    input  wire logic         op_req_i,
    input  wire logic [2:0]   status_i,
    output logic              op_done_o,
    output mci_pkg::mci_res_t op_res_o
);
    int cnt_q;
    // Count down, then pulse done; between answers the result toggles so stale data is never trusted
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q     <= 0;
            op_done_o <= 1'b0;
            op_res_o  <= '0;
        end else begin
            op_done_o <= (cnt_q == 1);
            op_res_o  <= (cnt_q == 1) ? {status_i, 16'h1234} : ~op_res_o;
            cnt_q     <= op_req_i ? DLY : (cnt_q > 0 ? cnt_q - 1 : 0);
        end
    end
endmodule : mci_engine_model

// ### bench/mailbox_command_interpreter_tb.sv
// Self-checking bench for the mailbox command interpreter.
// Assumes the core, its package and the engine model are compiled first.
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; $display("Error %0t: got %h want %h", $time, a, e); end end
module mailbox_command_interpreter_tb;
    typedef struct packed {
        logic [1:0] ssc;
        logic       lkl;
        logic [7:0] cmd;
        logic [7:0] p1;
        logic [2:0] st;
        logic [3:0] nib;
    } mci_row_t;
    logic clk_i = 0, lk_clk_i = 0, sys_rst_i = 1, lk_wr_i = 0, lk_rd_i = 0, lkl = 1;
    logic [4:0] lk_addr_i = '0;
    logic [7:0] lk_wdata_i = '0, rd;
    logic [1:0] ssc = '0;
    logic [2:0] eng_st = '0;
    logic lk_ready_o, lk_rvalid_o, op_req_o, op_done_i, reset_req_o, lock_set_o, lock_clr_o, busy_o;
    logic [7:0] lk_rdata_o;
    mci_pkg::mci_op_t  op_o;
    mci_pkg::mci_res_t op_res_i;
    int n_errors = 0, n_checks = 0, n_rst = 0, n_set = 0, n_clr = 0;
    // Security state, lock bit, command byte, mailbox 1, engine status, expected upper nibble
    mci_row_t rows [20] = '{
        '{2'h0,1'b1,8'h00,8'h00,3'h0,4'h8}, '{2'h2,1'b1,8'h00,8'h00,3'h0,4'hb},
        '{2'h1,1'b1,8'h00,8'h00,3'h0,4'h8}, '{2'h3,1'b1,8'h00,8'h00,3'h0,4'h8},
        '{2'h2,1'b1,8'h08,8'h00,3'h0,4'hb}, '{2'h0,1'b1,8'h08,8'h00,3'h0,4'h8},
        '{2'h0,1'b0,8'h09,8'h00,3'h0,4'ha}, '{2'h0,1'b1,8'h09,8'h00,3'h5,4'hd},
        '{2'h0,1'b1,8'h0b,8'h00,3'h4,4'hc}, '{2'h0,1'b1,8'h09,8'h00,3'h4,4'h8},
        '{2'h0,1'b1,8'h08,8'h00,3'h6,4'he}, '{2'h2,1'b1,8'h10,8'h00,3'h0,4'hb},
        '{2'h2,1'b0,8'h38,8'h00,3'h0,4'h8}, '{2'h2,1'b1,8'h40,8'h00,3'h0,4'h8},
        '{2'h2,1'b1,8'h10,8'h01,3'h0,4'h8}, '{2'h0,1'b0,8'h10,8'h01,3'h0,4'ha},
        '{2'h2,1'b1,8'h20,8'h00,3'h0,4'hb}, '{2'h0,1'b1,8'h20,8'h00,3'h1,4'h9},
        '{2'h0,1'b1,8'h18,8'h00,3'h0,4'hf}, '{2'h0,1'b1,8'hf8,8'h00,3'h0,4'hf}
    };

    mci_core #(.DEV_ID(32'h1234_5678)) uut ( // Arbitrary identifier value
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .lk_clk_i(lk_clk_i), .lk_wr_i(lk_wr_i), .lk_rd_i(lk_rd_i),
        .lk_addr_i(lk_addr_i), .lk_wdata_i(lk_wdata_i), .lk_ready_o(lk_ready_o), .lk_rvalid_o(lk_rvalid_o),
        .lk_rdata_o(lk_rdata_o), .security_state_code_i(ssc), .flash_write_lock_low_i(lkl),
        .op_req_o(op_req_o), .op_o(op_o), .op_done_i(op_done_i), .op_res_i(op_res_i),
        .reset_req_o(reset_req_o), .lock_set_o(lock_set_o), .lock_clr_o(lock_clr_o), .busy_o(busy_o));
    mci_engine_model eng (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .op_req_i(op_req_o), .status_i(eng_st),
        .op_done_o(op_done_i), .op_res_o(op_res_i));

    // Two unrelated clocks: 100 ns device, 125 ns link
    initial forever #50 clk_i = ~clk_i;
    initial begin
        #17;
        forever begin
            #62 lk_clk_i = ~lk_clk_i;
            #63 lk_clk_i = ~lk_clk_i;
        end
    end
    // Count side-effect pulses
    always @(posedge clk_i) begin
        n_rst += int'(reset_req_o === 1'b1);
        n_set += int'(lock_set_o === 1'b1);
        n_clr += int'(lock_clr_o === 1'b1);
    end

    task automatic close_out;
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    // One link access; request held until taken, then wait for ready or read data
    task automatic acc(input logic rd_en, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        int k;
        @(negedge lk_clk_i);
        lk_addr_i = a;
        lk_wdata_i = d;
        lk_wr_i = ~rd_en;
        lk_rd_i = rd_en;
        do @(posedge lk_clk_i); while (lk_ready_o !== 1'b1);
        @(negedge lk_clk_i);
        lk_wr_i = 1'b0;
        lk_rd_i = 1'b0;
        lk_wdata_i = ~d;
        q = 8'h00;
        for (k = 0; k < 40; k++) begin
            @(negedge lk_clk_i);
            if (rd_en ? lk_rvalid_o === 1'b1 : lk_ready_o === 1'b1) begin
                q = lk_rdata_o;
                break;
            end
        end
        // A lost answer is a mismatch, not a silent pass
        if (k == 40) begin
            n_errors++;
            $display("Error %0t: link access not answered", $time);
        end
    endtask : acc

    // Start a command, poll until complete, check status nibble and echo
    task automatic run(input logic [7:0] cmd, input logic [3:0] nib);
        logic [7:0] v;
        acc(1'b0, 5'h00, cmd, v);
        v = 8'h00;
        for (int k = 0; k < 50 && v[7] !== 1'b1; k++) acc(1'b1, 5'h01, 8'h00, v);
        `CHK(v[7:4], nib)
        acc(1'b1, 5'h00, 8'h00, v);
        `CHK(v, cmd)
        `CHK(busy_o, 1'b0)
    endtask : run

    initial begin
        #4_000_000;
        n_errors++;
        $display("Error %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        `CHK(busy_o, 1'b0)
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        foreach (rows[i]) begin
            @(negedge clk_i);
            ssc = rows[i].ssc;
            lkl = rows[i].lkl;
            eng_st = rows[i].st;
            for (int a = 7; a >= 1; a--) acc(1'b0, a[4:0], a == 1 ? rows[i].p1 : 8'h00, rd);
            run(rows[i].cmd, rows[i].nib);
            if (rows[i].nib == 4'hc) begin
                acc(1'b1, 5'h02, 8'h00, rd);
                `CHK(rd, 8'h12)
                acc(1'b1, 5'h03, 8'h00, rd);
                `CHK(rd, 8'h34)
            end
            if (rows[i].cmd == 8'h00) begin
                acc(1'b1, 5'h11, 8'h00, rd);
                `CHK(rd, {6'h00, rows[i].ssc})
                acc(1'b1, 5'h05, 8'h00, rd);
                `CHK(rd, 8'h78)
            end
        end
        `CHK(n_set, 1)
        `CHK(n_clr, 1)
        `CHK(op_o.kind, mci_pkg::MCI_OP_CSUM)
        // Command byte alone for a memory access is an incomplete packet
        run(8'h08, 4'hf);
        // Reset command: side-effect pulse, no response
        acc(1'b0, 5'h00, 8'h28, rd);
        repeat (20) @(negedge lk_clk_i);
        acc(1'b1, 5'h01, 8'h00, rd);
        `CHK(rd[7], 1'b0)
        `CHK(n_rst, 1)
        close_out();
    end
endmodule : mailbox_command_interpreter_tb
